//--- dv/rsc_reset_ctrl_tb.sv
module rsc_reset_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rsc_pkg::*;
   localparam int PWR_CYC = 20;
   logic clk = 0, rst_n = 0, prog = 0, pin_en = 1, low_voltage_prog_enable = 0, pu_sw = 0, tmr_en_n = 0, osc_req = 1;
   logic wdt = 0, sleep = 0, irq = 0, global_irq_enable = 0, instr = 0, stk_en = 0, ovf = 0, unf = 0, wr = 0;
   logic [7:0] wdata = 8'h00;
   rsc_pc_t pc = 15'h0123;
   logic pin, pwr_on, brown, osc_done, core_rst, pc_ld, vec_req, to_n, pd_n, oe, pu, gpio;
   rsc_pc_t pc_val, vec;
   logic [7:0] power_control_reg;
   int err_count = 0, tests_run = 0, n;
   always #4 clk = ~clk;
   rsc_supply_model i_rsc_supply_model (.clk_in(clk), .pin_out(pin), .pwr_on_out(pwr_on), .brown_out(brown),
      .osc_done_out(osc_done));
   rsc_reset_ctrl #(.POWERUP_TIMER_CYCLES(PWR_CYC)) i_rsc_reset_ctrl (.ref_clk_in(clk), .reset_n_in(rst_n),
      .por_event_in(pwr_on), .bor_event_in(brown), .prog_exit_in(prog), .ext_reset_pin_in(pin),
      .ext_reset_pin_enable_in(pin_en), .low_voltage_prog_enable_in(low_voltage_prog_enable), .pullup_sw_in(pu_sw),
      .powerup_timer_enable_n_in(tmr_en_n), .osc_startup_required_in(osc_req), .osc_startup_done_in(osc_done),
      .wdt_timeout_in(wdt), .sleep_in(sleep), .irq_wake_in(irq), .global_irq_enable_in(global_irq_enable),
      .reset_instr_in(instr), .stack_reset_enable_in(stk_en), .stack_overrun_in(ovf), .stack_underrun_in(unf),
      .pc_in(pc), .power_control_reg_wr_in(wr), .power_control_reg_wr_data_in(wdata), .core_reset_out(core_rst), .pc_load_out(pc_ld),
      .pc_load_value_out(pc_val), .irq_vector_req_out(vec_req), .irq_vector_out(vec),
      .power_control_reg_out(power_control_reg), .timeout_flag_n_out(to_n), .powerdown_flag_n_out(pd_n),
      .ext_reset_pin_oe_out(oe), .ext_reset_pin_pullup_out(pu), .ext_reset_pin_gpio_out(gpio));
   task chk(input string nm, input logic [14:0] e, input logic [14:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task final_report();
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One-cycle event: 0 wdt, 1 instr, 2 ovf, 3 unf, 4 irq, 5 prog, 6 write
   task ev(input int k);
      @(posedge clk);
      case (k)
         0: wdt <= 1'b1;
         1: instr <= 1'b1;
         2: ovf <= 1'b1;
         3: unf <= 1'b1;
         4: irq <= 1'b1;
         5: prog <= 1'b1;
         default: wr <= 1'b1;
      endcase
      @(posedge clk);
      {wdt, instr, ovf, unf, irq, prog, wr} <= 7'h00;
      #1;
   endtask
   task wr_power_control_reg(input logic [7:0] d);
      wdata <= d;
      ev(6);
   endtask
   // Wait for release; check the restart vector on that cycle
   task wait_run(input int bound, output int cnt);
      cnt = 0;
      while (core_rst !== 1'b0 && cnt < bound) begin
         @(posedge clk);
         #1;
         cnt++;
      end
      chk("release", 1'b1, cnt < bound);
      chk("restart load", 1'b1, pc_ld);
      chk("restart pc", 15'h0000, pc_val);
   endtask
   initial begin
      #50us;
      err_count++;
      $display("BAD watchdog expected done seen hang");
      final_report();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("cause reset", 8'h0c, power_control_reg);
      chk("oe", 1'b0, oe);
      wait_run(100, n);
      chk("startup delay", 1'b1, n >= PWR_CYC);
      chk("delay length", 1'b1, n <= PWR_CYC + 12);
      $display("test startup done");
      wr_power_control_reg(8'hff);
      chk("masked write", 8'hcf, power_control_reg);
      ev(0);
      chk("wdt reset", 1'b1, core_rst);
      chk("wdt flag", 1'b0, to_n);
      chk("wdt power_control_reg", 8'hcf, power_control_reg);
      wait_run(10, n);
      ev(1);
      chk("instr power_control_reg", 8'hcb, power_control_reg);
      wait_run(10, n);
      wr_power_control_reg(8'h0f);
      ev(2);
      chk("stack off", 1'b0, core_rst);
      stk_en <= 1'b1;
      ev(2);
      chk("overrun power_control_reg", 8'h8f, power_control_reg);
      wait_run(10, n);
      ev(3);
      chk("underrun power_control_reg", 8'hcf, power_control_reg);
      wait_run(10, n);
      $display("test events done");
      sleep <= 1'b1;
      ev(1);
      chk("instr asleep", 1'b0, core_rst);
      ev(0);
      chk("wake run", 1'b0, core_rst);
      chk("wake load", 1'b1, pc_ld);
      chk("wake pc", 15'h0124, pc_val);
      chk("wake flags", 2'b00, {to_n, pd_n});
      global_irq_enable <= 1'b1;
      ev(4);
      chk("irq pc", 15'h0124, pc_val);
      chk("irq req", 1'b1, vec_req);
      chk("irq vec", 15'h0004, vec);
      chk("irq flags", 2'b10, {to_n, pd_n});
      sleep <= 1'b0;
      $display("test wake done");
      i_rsc_supply_model.pin_low(10);
      repeat (30) @(posedge clk);
      #1;
      chk("glitch", 1'b0, core_rst);
      i_rsc_supply_model.pin_low(40);
      #1;
      chk("pin held", 1'b1, core_rst);
      chk("pin power_control_reg", 8'hc7, power_control_reg);
      chk("pin oe", 1'b0, oe);
      wait_run(40, n);
      chk("pin filter", 1'b1, n >= 20);
      $display("test pin done");
      pin_en <= 1'b0;
      pu_sw <= 1'b1;
      i_rsc_supply_model.pin_low(40);
      #1;
      chk("disabled", 1'b0, core_rst);
      chk("gpio low", 1'b0, gpio);
      chk("sw pullup", 1'b1, pu);
      pu_sw <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("gpio high", 1'b1, gpio);
      chk("pullup off", 1'b0, pu);
      low_voltage_prog_enable <= 1'b1;
      @(posedge clk);
      #1;
      chk("lvp pullup", 1'b1, pu);
      $display("test gpio done");
      wr_power_control_reg(8'hcf);
      i_rsc_supply_model.supply(1'b1, 5);
      wait_run(100, n);
      chk("brown delay", 1'b1, n >= PWR_CYC);
      chk("brown power_control_reg", 8'h0e, power_control_reg);
      chk("brown flags", 2'b11, {to_n, pd_n});
      wr_power_control_reg(8'hcf);
      fork
         i_rsc_supply_model.pin_low(100);
         i_rsc_supply_model.supply(1'b0, 5);
      join
      wait_run(60, n);
      chk("quick start", 1'b1, n <= 30);
      chk("on power_control_reg", 8'h0c, power_control_reg & 8'hfe);
      wr_power_control_reg(8'hcf);
      tmr_en_n <= 1'b1;
      osc_req <= 1'b0;
      ev(5);
      chk("prog reset", 1'b1, core_rst);
      wait_run(100, n);
      chk("no timer", 1'b1, n < PWR_CYC);
      chk("prog power_control_reg", 8'h0c, power_control_reg & 8'hfe);
      $display("test supply done");
      final_report();
   end
endmodule // rsc_reset_ctrl_tb

//--- dv/rsc_supply_model.sv
module rsc_supply_model #(
   parameter int OSC_CYC = 8
) (
   input wire logic clk_in, // System clock
   output logic pin_out, // Reset pin level, weak pull-up
   output logic pwr_on_out, // Power-on detector
   output logic brown_out, // Brown-out detector
   output logic osc_done_out // Oscillator start-up expired
);
   timeunit 1ns;
   timeprecision 1ps;
   int osc_cnt = 0;
   initial begin
      pin_out = 1'b1;
      pwr_on_out = 1'b0;
      brown_out = 1'b0;
   end
   // Oscillator timer restarts on a supply event and ignores the pin
   always @(posedge clk_in) begin
      if (pwr_on_out || brown_out) osc_cnt <= 0;
      else if (osc_cnt < OSC_CYC) osc_cnt <= osc_cnt + 1;
   end
   assign osc_done_out = (osc_cnt >= OSC_CYC) && !pwr_on_out && !brown_out;
   // Released pin returns to the pull-up level
   task pin_low(input int n);
      @(posedge clk_in);
      pin_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      pin_out <= 1'b1;
   endtask
   task supply(input bit brown, input int n);
      @(posedge clk_in);
      if (brown) brown_out <= 1'b1;
      else pwr_on_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      brown_out <= 1'b0;
      pwr_on_out <= 1'b0;
   endtask
endmodule // rsc_supply_model

//--- logic/rsc_defines.svh
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// Clock and timing
`define RSC_CLK_MHZ 125
`define RSC_POWERUP_TIMER_MS 64
`define RSC_FILTER_NS 200
`define RSC_FILTER_CYC ((`RSC_FILTER_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_POWERUP_TIMER_CYC (`RSC_POWERUP_TIMER_MS * 1000 * `RSC_CLK_MHZ)

// Program counter vectors
`define RSC_RESET_VECTOR 15'h0000
`define RSC_IRQ_VECTOR 15'h0004
`define RSC_PC_STEP 15'h0001

// Power control register fields
`define RSC_OVF_BIT 7
`define RSC_UNF_BIT 6
`define RSC_PIN_BIT 3
`define RSC_RI_BIT 2
`define RSC_POR_BIT 1
`define RSC_BOR_BIT 0
`define RSC_POWER_CONTROL_REG_MASK 8'hcf
`define RSC_POWER_CONTROL_REG_RESET 8'h0c

`endif

//--- logic/rsc_pin_filter.sv
`include "rsc_defines.svh"

module rsc_pin_filter #(
   parameter int CYC = `RSC_FILTER_CYC
) (
   input wire logic clk_in, // System clock
   input wire logic reset_n_in, // Async reset, active low
   input wire logic raw_in, // Pin level as sampled
   output logic filt_out // Pin level after glitch rejection
);
   localparam logic [7:0] CNT_LAST = 8'(CYC - 1);

   logic filt_reg;
   logic [7:0] cnt_reg;
   wire differ = raw_in != filt_reg;
   wire flip = differ && (cnt_reg == CNT_LAST);

   // Level must differ for CYC cycles in a row before it is taken
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         filt_reg <= 1'b1;
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= (differ && !flip) ? cnt_reg + 8'h01 : 8'h00;
         if (flip) begin
            filt_reg <= raw_in;
         end
      end
   end

   assign filt_out = filt_reg;

   property p_filter_stable;
      @(posedge clk_in) disable iff (!reset_n_in)
         $changed(filt_reg) |-> $past(cnt_reg) == CNT_LAST && $past(differ);
   endproperty
   a_filter_stable: assert property (p_filter_stable) else $error("Pin filter passed a short pulse");
endmodule // rsc_pin_filter

//--- logic/rsc_pkg.sv
package rsc_pkg;
   typedef logic [14:0] rsc_pc_t;
   typedef enum logic [1:0] {
      ST_HOLD = 2'b01,
      ST_RUN = 2'b10
   } rsc_state_t;
endpackage

//--- logic/rsc_reset_ctrl.sv
`include "rsc_defines.svh"

module rsc_reset_ctrl #(
   parameter int unsigned POWERUP_TIMER_CYCLES = `RSC_POWERUP_TIMER_CYC
) (
   input wire logic ref_clk_in, // 125 MHz system clock
   input wire logic reset_n_in, // Async power-on reset, active low
   input wire logic por_event_in, // Power-on detector active
   input wire logic bor_event_in, // Brown-out detector active
   input wire logic prog_exit_in, // Leaving programming mode, pulse
   input wire logic ext_reset_pin_in, // External reset pin level
   input wire logic ext_reset_pin_enable_in, // Pin reset enable config bit
   input wire logic low_voltage_prog_enable_in, // Low-voltage programming bit
   input wire logic pullup_sw_in, // Software pull-up control
   input wire logic powerup_timer_enable_n_in, // Power-up timer enable, active low
   input wire logic osc_startup_required_in, // Oscillator needs start-up timer
   input wire logic osc_startup_done_in, // Oscillator start-up timer expired
   input wire logic wdt_timeout_in, // Watchdog time-out pulse
   input wire logic sleep_in, // Core is asleep
   input wire logic irq_wake_in, // Interrupt wake request
   input wire logic global_irq_enable_in, // Global interrupt enable
   input wire logic reset_instr_in, // Reset instruction executed
   input wire logic stack_reset_enable_in, // Stack reset config bit
   input wire logic stack_overrun_in, // Stack overflow event
   input wire logic stack_underrun_in, // Stack underflow event
   input wire rsc_pkg::rsc_pc_t pc_in, // Current program counter
   input wire logic power_control_reg_wr_in, // Firmware write of power control
   input wire logic [7:0] power_control_reg_wr_data_in, // Firmware write data
   output logic core_reset_out, // Internal reset to the core
   output logic pc_load_out, // Load program counter, pulse
   output rsc_pkg::rsc_pc_t pc_load_value_out, // Program counter load value
   output logic irq_vector_req_out, // Vector to 0004h after next instr
   output rsc_pkg::rsc_pc_t irq_vector_out, // Interrupt vector address
   output logic [7:0] power_control_reg_out, // Reset cause flags
   output logic timeout_flag_n_out, // Time-out flag, active low
   output logic powerdown_flag_n_out, // Power-down flag, active low
   output logic ext_reset_pin_oe_out, // Pin output enable, always off
   output logic ext_reset_pin_pullup_out, // Weak pull-up enable
   output logic ext_reset_pin_gpio_out // Pin level as general input
);
   import rsc_pkg::*;

   localparam logic [23:0] POWERUP_TIMER_LAST = 24'(POWERUP_TIMER_CYCLES - 1);

   rsc_state_t state_reg, state_next;
   logic [7:0] power_control_reg_reg, power_control_reg_next;
   logic to_n_reg, to_n_next;
   logic pd_n_reg, pd_n_next;
   logic powerup_timer_pend_reg;
   logic osc_pend_reg;
   logic [23:0] powerup_timer_cnt_reg;
   logic pc_load_reg;
   rsc_pc_t pc_val_reg;
   logic vec_req_reg;
   logic gpio_reg;
   logic pin_filt;

   rsc_pin_filter #(
      .CYC(`RSC_FILTER_CYC)
   ) i_rsc_pin_filter (
      .clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .raw_in(ext_reset_pin_in),
      .filt_out(pin_filt)
   );

   // Decode of sources
   wire run = state_reg == ST_RUN;
   wire pin_enabled = low_voltage_prog_enable_in | ext_reset_pin_enable_in;
   wire pin_low = pin_enabled & ~pin_filt;
   wire supply_hold = por_event_in | bor_event_in;
   wire por_like = por_event_in | prog_exit_in;
   wire supply_evt = supply_hold | prog_exit_in;
   wire wdt_reset = run & wdt_timeout_in & ~sleep_in;
   wire wdt_wake = run & wdt_timeout_in & sleep_in;
   wire irq_wake = run & irq_wake_in & sleep_in & ~wdt_timeout_in;
   wire instr_reset = run & reset_instr_in & ~sleep_in;
   wire ovf_reset = run & stack_reset_enable_in & stack_overrun_in;
   wire unf_reset = run & stack_reset_enable_in & stack_underrun_in;
   wire pin_reset = run & pin_low;
   wire any_reset = supply_evt | wdt_reset | instr_reset | ovf_reset | unf_reset | pin_reset;
   wire powerup_timer_run = powerup_timer_pend_reg & ~supply_hold & ~powerup_timer_enable_n_in;
   wire powerup_timer_done = powerup_timer_run & (powerup_timer_cnt_reg == POWERUP_TIMER_LAST);
   wire osc_ready = ~osc_pend_reg | osc_startup_done_in;
   wire release_ok = ~supply_evt & ~powerup_timer_pend_reg & ~osc_pend_reg & ~pin_low;
   wire start = ~run & release_ok;
   wire wake = wdt_wake | (irq_wake & ~any_reset);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD: begin
            if (release_ok) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_reset) begin
               state_next = ST_HOLD;
            end
         end
         default: begin
            state_next = ST_HOLD;
         end
      endcase
   end

   // Firmware write first, hardware events override it
   always_comb begin
      power_control_reg_next = power_control_reg_reg;
      to_n_next = to_n_reg;
      pd_n_next = pd_n_reg;
      if (power_control_reg_wr_in) begin
         power_control_reg_next = power_control_reg_wr_data_in & `RSC_POWER_CONTROL_REG_MASK;
      end
      if (por_like) begin
         power_control_reg_next[`RSC_OVF_BIT] = 1'b0;
         power_control_reg_next[`RSC_UNF_BIT] = 1'b0;
         power_control_reg_next[`RSC_PIN_BIT] = 1'b1;
         power_control_reg_next[`RSC_RI_BIT] = 1'b1;
         power_control_reg_next[`RSC_POR_BIT] = 1'b0;
         to_n_next = 1'b1;
         pd_n_next = 1'b1;
      end else if (bor_event_in) begin
         power_control_reg_next[`RSC_OVF_BIT] = 1'b0;
         power_control_reg_next[`RSC_UNF_BIT] = 1'b0;
         power_control_reg_next[`RSC_PIN_BIT] = 1'b1;
         power_control_reg_next[`RSC_RI_BIT] = 1'b1;
         power_control_reg_next[`RSC_BOR_BIT] = 1'b0;
         to_n_next = 1'b1;
         pd_n_next = 1'b1;
      end else begin
         if (pin_reset) begin
            power_control_reg_next[`RSC_PIN_BIT] = 1'b0;
            if (sleep_in) begin
               to_n_next = 1'b1;
               pd_n_next = 1'b0;
            end
         end
         if (wdt_reset) begin
            to_n_next = 1'b0;
         end
         if (wdt_wake) begin
            to_n_next = 1'b0;
            pd_n_next = 1'b0;
         end
         if (irq_wake && !pin_reset) begin
            to_n_next = 1'b1;
            pd_n_next = 1'b0;
         end
         if (instr_reset) begin
            power_control_reg_next[`RSC_RI_BIT] = 1'b0;
         end
         if (ovf_reset) begin
            power_control_reg_next[`RSC_OVF_BIT] = 1'b1;
         end
         if (unf_reset) begin
            power_control_reg_next[`RSC_UNF_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= ST_HOLD;
         power_control_reg_reg <= `RSC_POWER_CONTROL_REG_RESET;
         to_n_reg <= 1'b1;
         pd_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         power_control_reg_reg <= power_control_reg_next;
         to_n_reg <= to_n_next;
         pd_n_reg <= pd_n_next;
      end
   end

   // Start-up timers run regardless of the pin
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         powerup_timer_pend_reg <= 1'b1;
         osc_pend_reg <= 1'b1;
         powerup_timer_cnt_reg <= 24'h000000;
      end else begin
         if (supply_evt) begin
            powerup_timer_pend_reg <= 1'b1;
            powerup_timer_cnt_reg <= 24'h000000;
         end else if (powerup_timer_enable_n_in || powerup_timer_done) begin
            powerup_timer_pend_reg <= 1'b0;
         end else if (powerup_timer_run) begin
            powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 24'h000001;
         end
         if (supply_evt) begin
            osc_pend_reg <= osc_startup_required_in;
         end else if (osc_ready) begin
            osc_pend_reg <= 1'b0;
         end
      end
   end

   // Program counter loads on start and on wake
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_load_reg <= 1'b0;
         pc_val_reg <= `RSC_RESET_VECTOR;
         vec_req_reg <= 1'b0;
         gpio_reg <= 1'b1;
      end else begin
         pc_load_reg <= start | wake;
         vec_req_reg <= irq_wake & ~any_reset & global_irq_enable_in;
         if (start) begin
            pc_val_reg <= `RSC_RESET_VECTOR;
         end else if (wake) begin
            pc_val_reg <= pc_in + `RSC_PC_STEP;
         end
         gpio_reg <= pin_enabled ? 1'b0 : ext_reset_pin_in;
      end
   end

   assign core_reset_out = ~run;
   assign pc_load_out = pc_load_reg;
   assign pc_load_value_out = pc_val_reg;
   assign irq_vector_req_out = vec_req_reg;
   assign irq_vector_out = `RSC_IRQ_VECTOR;
   assign power_control_reg_out = power_control_reg_reg;
   assign timeout_flag_n_out = to_n_reg;
   assign powerdown_flag_n_out = pd_n_reg;
   assign ext_reset_pin_oe_out = 1'b0;
   assign ext_reset_pin_pullup_out = pin_enabled ? 1'b1 : pullup_sw_in;
   assign ext_reset_pin_gpio_out = gpio_reg;

   property p_pin_hold;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         pin_low |=> core_reset_out;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("Pin low did not hold reset");

   property p_pin_input;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         any_reset |=> !ext_reset_pin_oe_out;
   endproperty
   a_pin_input: assert property (p_pin_input) else $error("Reset drove the pin");

   property p_gpio_follow;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         !pin_enabled |=> ext_reset_pin_gpio_out == $past(ext_reset_pin_in);
   endproperty
   a_gpio_follow: assert property (p_gpio_follow) else $error("Pin not usable as input");

   property p_wdt_reset;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         wdt_reset && !supply_evt |=> core_reset_out && !timeout_flag_n_out;
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("Watchdog reset wrong");

   property p_instr_reset;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         instr_reset && !supply_evt |=> core_reset_out && !power_control_reg_out[`RSC_RI_BIT];
   endproperty
   a_instr_reset: assert property (p_instr_reset) else $error("Reset instruction flag wrong");

   property p_stack_reset;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         ovf_reset && !supply_evt |=> core_reset_out && power_control_reg_out[`RSC_OVF_BIT];
   endproperty
   a_stack_reset: assert property (p_stack_reset) else $error("Stack reset flag wrong");

   property p_por_flags;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         por_like |=> power_control_reg_out[3:1] == 3'b110 && power_control_reg_out[7:6] == 2'b00
            && timeout_flag_n_out && powerdown_flag_n_out;
   endproperty
   a_por_flags: assert property (p_por_flags) else $error("Power-on flags wrong");

   property p_release;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         start |=> !core_reset_out && pc_load_out && pc_load_value_out == `RSC_RESET_VECTOR;
   endproperty
   a_release: assert property (p_release) else $error("Start-up release wrong");

   property p_wdt_wake;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         wdt_wake && !any_reset |=> pc_load_out && !core_reset_out
            && pc_load_value_out == $past(pc_in) + `RSC_PC_STEP && !timeout_flag_n_out && !powerdown_flag_n_out;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("Watchdog wake wrong");

   property p_irq_wake;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         irq_wake && !any_reset && global_irq_enable_in |=> irq_vector_req_out && pc_load_out
            && timeout_flag_n_out && !powerdown_flag_n_out;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("Interrupt wake wrong");

   property p_powerup_timer_hold;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         $rose(powerup_timer_run) |-> core_reset_out [*8];
   endproperty
   a_powerup_timer_hold: assert property (p_powerup_timer_hold) else $error("Power-up timer did not hold");

   property p_unimpl_zero;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         power_control_reg_wr_in |=> power_control_reg_out[5:4] == 2'b00;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bits set");

   property p_bor_flags;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         bor_event_in && !por_like |=> !power_control_reg_out[`RSC_BOR_BIT] && power_control_reg_out[7:6] == 2'b00
            && power_control_reg_out[`RSC_PIN_BIT] && power_control_reg_out[`RSC_RI_BIT];
   endproperty
   a_bor_flags: assert property (p_bor_flags) else $error("Brown-out flags wrong");

   property p_pin_flag;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         pin_reset && !supply_evt |=> core_reset_out && !power_control_reg_out[`RSC_PIN_BIT];
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("Pin reset flag wrong");

   property p_powerup_timer_count;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
         powerup_timer_run && !powerup_timer_done && !supply_evt |=> powerup_timer_cnt_reg == $past(powerup_timer_cnt_reg) + 24'h000001;
   endproperty
   a_powerup_timer_count: assert property (p_powerup_timer_count) else $error("Power-up timer stalled");
endmodule // rsc_reset_ctrl
